// [hw/drive_fieldbus_pkg.sv]
// Purpose: shared constants and types for the fieldbus control word decoder
// Assumes: byte stream from an RTU receiver on the same clock
// Notes: register addresses are zero-based bus addresses
package drive_fieldbus_pkg;
  localparam logic [7:0] FN_RW_MULTI = 8'h17;
  localparam int NREG = 8;
  localparam int NWBUF = 8;
  localparam int NDI = 6;
  localparam logic [15:0] NREG_W = 16'h0008;
  localparam logic [15:0] NWBUF_W = 16'h0008;
  localparam logic [15:0] MAX_RD_QTY = 16'h007D;
  localparam logic [15:0] REG_BASE = 16'h0000;
  localparam logic [15:0] IDX_CMD = 16'h0000;
  localparam logic [15:0] IDX_STAT = 16'h0001;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  // request byte positions
  localparam logic [8:0] RQ_FUNC = 9'h001;
  localparam logic [8:0] RQ_RS_HI = 9'h002;
  localparam logic [8:0] RQ_RS_LO = 9'h003;
  localparam logic [8:0] RQ_RQ_HI = 9'h004;
  localparam logic [8:0] RQ_RQ_LO = 9'h005;
  localparam logic [8:0] RQ_WS_HI = 9'h006;
  localparam logic [8:0] RQ_WS_LO = 9'h007;
  localparam logic [8:0] RQ_WQ_HI = 9'h008;
  localparam logic [8:0] RQ_WQ_LO = 9'h009;
  localparam logic [8:0] RQ_BC = 9'h00A;
  localparam logic [8:0] RQ_DATA = 9'h00B;
  localparam logic [8:0] RQ_FIXED_LEN = 9'h00D;
  // response byte positions
  localparam logic [7:0] RSP_FUNC = 8'h01;
  localparam logic [7:0] RSP_BC = 8'h02;
  localparam logic [7:0] RSP_DATA = 8'h03;
  localparam logic [7:0] RSP_TAIL = 8'h04;
  // gating selections for bus bit versus digital input
  localparam logic [1:0] GATE_DI = 2'h0;
  localparam logic [1:0] GATE_BUS = 2'h1;
  localparam logic [1:0] GATE_OR = 2'h2;
  localparam logic [1:0] GATE_AND = 2'h3;
  // digital input bit positions
  localparam int DI_COAST_N = 0;
  localparam int DI_BRAKE_N = 1;
  localparam int DI_COAST_RST_N = 2;
  localparam int DI_UP = 3;
  localparam int DI_DOWN = 4;
  localparam int DI_REV = 5;
  // command word bit positions
  localparam int CW_REF_LO = 0;
  localparam int CW_REF_HI = 1;
  localparam int CW_BRAKE_N = 2;
  localparam int CW_COAST_N = 3;
  localparam int CW_QSTOP_N = 4;
  localparam int CW_HOLD_N = 5;
  localparam int CW_RUN = 6;
  localparam int CW_RESET = 7;
  localparam int CW_JOG = 8;
  localparam int CW_RAMP2 = 9;
  localparam int CW_VALID = 10;
  localparam int CW_RELAY1 = 11;
  localparam int CW_RELAY2 = 12;
  localparam int CW_SETUP = 13;
  localparam int CW_REVERSE = 15;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_RX = 4'b0010,
    S_WR = 4'b0100,
    S_TX = 4'b1000
  } fsm_t;
endpackage : drive_fieldbus_pkg

// [hw/drive_fieldbus_control_word_decoder.sv]
// Purpose: read/write-multiple telegram handler and drive command word decoder
// Assumes: rx bytes and frame end come from a receiver on clk; tx bytes drained by a sender
// Notes: holding register 0 is the write-only command word (reads return zero), 1 the decoded state, 2..7 plain storage
`timescale 1ns/1ns
`default_nettype none
module drive_fieldbus_control_word_decoder
  import drive_fieldbus_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] node_addr,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_frame_end,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic di_coast_n,
  input wire logic di_brake_n,
  input wire logic di_coast_rst_n,
  input wire logic di_speed_up,
  input wire logic di_speed_down,
  input wire logic di_reverse,
  input wire logic [1:0] coast_gate,
  input wire logic [1:0] reverse_gate,
  input wire logic relay1_fn_cw,
  input wire logic relay2_fn_cw,
  input wire logic multi_setup_en,
  output logic [1:0] preset_sel,
  output logic dc_brake,
  output logic motor_coast,
  output logic quick_stop,
  output logic freq_hold,
  output logic ramp_stop,
  output logic speed_up,
  output logic speed_down,
  output logic trip_reset,
  output logic jog,
  output logic ramp_set2,
  output logic relay1,
  output logic relay2,
  output logic setup_sel,
  output logic reverse
);

  typedef struct packed {
    fsm_t st;
    logic [8:0] rx_idx;
    logic bad;
    logic [15:0] crc;
    logic [15:0] rs;
    logic [15:0] rq;
    logic [15:0] ws;
    logic [15:0] wq;
    logic [7:0] bc;
    logic [NWBUF-1:0][15:0] wbuf;
    logic [NREG-1:0][15:0] regs;
    logic [15:0] wptr;
    logic [7:0] tx_idx;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [15:0] cmd;
    logic [NDI-1:0] s1;
    logic [NDI-1:0] s2;
    logic [NDI-1:0] s3;
    logic [NDI-1:0] di;
    logic [1:0] preset_sel;
    logic dc_brake;
    logic motor_coast;
    logic quick_stop;
    logic freq_hold;
    logic ramp_stop;
    logic speed_up;
    logic speed_down;
    logic trip_reset;
    logic jog;
    logic ramp_set2;
    logic relay1;
    logic relay2;
    logic setup_sel;
    logic reverse;
  } state_t;

  localparam state_t STATE_RST = '{st: S_IDLE, crc: CRC_INIT, cmd: CMD_RST, default: '0};

  state_t state_ff;
  state_t nxt_state;

  // reflected CRC-16 as used on RTU links
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_upd

  function automatic logic gate_sel(input logic [1:0] sel, input logic bus, input logic dig);
    logic r;
    case (sel)
      GATE_BUS: r = bus;
      GATE_OR: r = bus | dig;
      GATE_AND: r = bus & dig;
      default: r = dig;
    endcase
    return r;
  endfunction : gate_sel

  always_comb
  begin : next_logic
    logic [8:0] off;
    logic [15:0] widx;
    logic [15:0] ridx;
    logic [15:0] w;
    logic [15:0] rword;
    logic [7:0] nidx;
    logic [7:0] bcr;
    logic [7:0] k;
    logic ok;
    logic coast_req;
    logic brake_req;
    logic hold;
    nxt_state = state_ff;
    off = 9'(state_ff.rx_idx - RQ_DATA);
    widx = 16'(state_ff.ws + state_ff.wptr - REG_BASE);
    w = state_ff.wbuf[state_ff.wptr[2:0]];
    nidx = 8'(state_ff.tx_idx + 8'h01);
    bcr = {state_ff.rq[6:0], 1'b0};
    k = 8'(nidx - RSP_DATA) >> 1;
    ridx = 16'(state_ff.rs + {8'h00, k} - REG_BASE);
    rword = (ridx < NREG_W) ? state_ff.regs[ridx[2:0]] : 16'h0000;
    ok = 1'b0;
    coast_req = gate_sel(coast_gate, ~state_ff.cmd[CW_COAST_N],
      ~state_ff.di[DI_COAST_N] | ~state_ff.di[DI_COAST_RST_N]);
    brake_req = ~state_ff.cmd[CW_BRAKE_N] | ~state_ff.di[DI_BRAKE_N];
    hold = ~state_ff.cmd[CW_HOLD_N];
    nxt_state.trip_reset = 1'b0;

    // pin inputs: a change counts once stages two and three agree
    nxt_state.s1 = {di_reverse, di_speed_down, di_speed_up, di_coast_rst_n, di_brake_n, di_coast_n};
    nxt_state.s2 = state_ff.s1;
    nxt_state.s3 = state_ff.s2;
    nxt_state.di = (~(state_ff.s2 ^ state_ff.s3) & state_ff.s3)
                 | ((state_ff.s2 ^ state_ff.s3) & state_ff.di);

    // decoded state mirrored into the read-only register
    nxt_state.regs[IDX_STAT[2:0]] = {5'h00, state_ff.reverse, state_ff.setup_sel,
      state_ff.relay2, state_ff.relay1, state_ff.ramp_set2, state_ff.jog,
      state_ff.ramp_stop, state_ff.freq_hold, state_ff.quick_stop,
      state_ff.motor_coast, state_ff.dc_brake};

    unique case (state_ff.st)
      S_IDLE:
      begin
        if (rx_valid)
        begin
          nxt_state.st = S_RX;
          nxt_state.rx_idx = 9'h001;
          nxt_state.crc = crc_upd(CRC_INIT, rx_data);
          nxt_state.bad = (rx_data != node_addr);
        end
      end
      S_RX:
      begin
        if (rx_valid)
        begin
          nxt_state.crc = crc_upd(state_ff.crc, rx_data);
          if (state_ff.rx_idx != 9'h1FF)
          begin
            nxt_state.rx_idx = 9'(state_ff.rx_idx + 9'h001);
          end
          case (state_ff.rx_idx)
            RQ_FUNC: nxt_state.bad = state_ff.bad | (rx_data != FN_RW_MULTI);
            RQ_RS_HI: nxt_state.rs[15:8] = rx_data;
            RQ_RS_LO: nxt_state.rs[7:0] = rx_data;
            RQ_RQ_HI: nxt_state.rq[15:8] = rx_data;
            RQ_RQ_LO: nxt_state.rq[7:0] = rx_data;
            RQ_WS_HI: nxt_state.ws[15:8] = rx_data;
            RQ_WS_LO: nxt_state.ws[7:0] = rx_data;
            RQ_WQ_HI: nxt_state.wq[15:8] = rx_data;
            RQ_WQ_LO: nxt_state.wq[7:0] = rx_data;
            RQ_BC: nxt_state.bc = rx_data;
            default:
            begin
              // high byte lands first in each word
              if (off < {1'b0, state_ff.bc} && off[8:4] == 5'h00)
              begin
                if (off[0])
                begin
                  nxt_state.wbuf[off[3:1]][7:0] = rx_data;
                end
                else
                begin
                  nxt_state.wbuf[off[3:1]][15:8] = rx_data;
                end
              end
            end
          endcase
        end
        else if (rx_frame_end)
        begin
          // residue of zero over message plus check means intact
          ok = !state_ff.bad && state_ff.crc == 16'h0000
            && state_ff.rx_idx == 9'(RQ_FIXED_LEN + {1'b0, state_ff.bc})
            && state_ff.wq != 16'h0000 && state_ff.wq <= NWBUF_W
            && {8'h00, state_ff.bc} == 16'(state_ff.wq << 1)
            && state_ff.rq != 16'h0000 && state_ff.rq <= MAX_RD_QTY;
          nxt_state.st = ok ? S_WR : S_IDLE;
          nxt_state.wptr = 16'h0000;
        end
      end
      S_WR:
      begin
        // one word per cycle; a 32-bit value is two adjacent words
        if (widx == IDX_CMD)
        begin
          if (w[CW_VALID])
          begin
            nxt_state.cmd = w;
            nxt_state.trip_reset = w[CW_RESET] & ~state_ff.cmd[CW_RESET];
          end
        end
        else if (widx != IDX_STAT && widx < NREG_W)
        begin
          nxt_state.regs[widx[2:0]] = w;
        end
        nxt_state.wptr = 16'(state_ff.wptr + 16'h0001);
        if (state_ff.wptr == 16'(state_ff.wq - 16'h0001))
        begin
          // answer only after every write has landed
          nxt_state.st = S_TX;
          nxt_state.tx_idx = 8'h00;
          nxt_state.tx_data = node_addr;
          nxt_state.tx_valid = 1'b1;
          nxt_state.crc = CRC_INIT;
        end
      end
      S_TX:
      begin
        if (state_ff.tx_valid && tx_ready)
        begin
          // check bytes are not folded into the running check
          if (state_ff.tx_idx < 8'(bcr + RSP_DATA))
          begin
            nxt_state.crc = crc_upd(state_ff.crc, state_ff.tx_data);
          end
          if (state_ff.tx_idx == 8'(bcr + RSP_TAIL))
          begin
            nxt_state.tx_valid = 1'b0;
            nxt_state.st = S_IDLE;
          end
          else
          begin
            nxt_state.tx_idx = nidx;
            if (nidx == RSP_FUNC)
            begin
              nxt_state.tx_data = FN_RW_MULTI;
            end
            else if (nidx == RSP_BC)
            begin
              nxt_state.tx_data = bcr;
            end
            else if (nidx < 8'(bcr + RSP_DATA))
            begin
              nxt_state.tx_data = nidx[0] ? rword[15:8] : rword[7:0];
            end
            else if (nidx == 8'(bcr + RSP_DATA))
            begin
              nxt_state.tx_data = nxt_state.crc[7:0];
            end
            else
            begin
              nxt_state.tx_data = state_ff.crc[15:8];
            end
          end
        end
      end
    endcase

    // command word decode; bit 14 has no function and is never looked at
    nxt_state.preset_sel = state_ff.cmd[CW_REF_HI:CW_REF_LO];
    nxt_state.dc_brake = brake_req;
    nxt_state.motor_coast = coast_req;
    nxt_state.freq_hold = hold;
    // a frozen output ignores the ramped stop paths
    nxt_state.quick_stop = ~state_ff.cmd[CW_QSTOP_N] & ~hold;
    nxt_state.ramp_stop = ~state_ff.cmd[CW_RUN] & ~hold;
    nxt_state.speed_up = hold & state_ff.di[DI_UP];
    nxt_state.speed_down = hold & state_ff.di[DI_DOWN];
    nxt_state.jog = state_ff.cmd[CW_JOG];
    nxt_state.ramp_set2 = state_ff.cmd[CW_RAMP2];
    nxt_state.relay1 = state_ff.cmd[CW_RELAY1] & relay1_fn_cw;
    nxt_state.relay2 = state_ff.cmd[CW_RELAY2] & relay2_fn_cw;
    nxt_state.setup_sel = state_ff.cmd[CW_SETUP] & multi_setup_en;
    // bus-only selection does not let the bus reverse
    nxt_state.reverse = gate_sel((reverse_gate == GATE_BUS) ? GATE_DI : reverse_gate,
      state_ff.cmd[CW_REVERSE], state_ff.di[DI_REV]);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff <= STATE_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign tx_data = state_ff.tx_data;
  assign tx_valid = state_ff.tx_valid;
  assign preset_sel = state_ff.preset_sel;
  assign dc_brake = state_ff.dc_brake;
  assign motor_coast = state_ff.motor_coast;
  assign quick_stop = state_ff.quick_stop;
  assign freq_hold = state_ff.freq_hold;
  assign ramp_stop = state_ff.ramp_stop;
  assign speed_up = state_ff.speed_up;
  assign speed_down = state_ff.speed_down;
  assign trip_reset = state_ff.trip_reset;
  assign jog = state_ff.jog;
  assign ramp_set2 = state_ff.ramp_set2;
  assign relay1 = state_ff.relay1;
  assign relay2 = state_ff.relay2;
  assign setup_sel = state_ff.setup_sel;
  assign reverse = state_ff.reverse;

endmodule : drive_fieldbus_control_word_decoder
`default_nettype wire

// [verification/drive_fieldbus_props.sv]
// Purpose: port-level checks of the command word decoder
// Assumes: one clock, rst asynchronous and active high
// Notes: bound into every decoder instance
`timescale 1ns/1ns
`default_nettype none
module decoder_props
  import drive_fieldbus_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] node_addr,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic relay1_fn_cw,
  input wire logic relay2_fn_cw,
  input wire logic multi_setup_en,
  input wire logic relay1,
  input wire logic relay2,
  input wire logic setup_sel,
  input wire logic quick_stop,
  input wire logic ramp_stop,
  input wire logic freq_hold,
  input wire logic speed_up,
  input wire logic trip_reset,
  input wire logic reverse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_relay1_cfg: assert property (relay1 |-> $past(relay1_fn_cw)) else $error("relay one active unconfigured");
  a_relay2_cfg: assert property (relay2 |-> $past(relay2_fn_cw)) else $error("relay two active unconfigured");
  a_setup_cfg: assert property (setup_sel |-> $past(multi_setup_en)) else $error("setup select without multi");
  // both samples high so either hold timing is accepted
  a_hold_qstop: assert property (freq_hold && $past(freq_hold) |-> !quick_stop)
    else $error("quick stop in hold");
  a_hold_rstop: assert property (freq_hold && $past(freq_hold) |-> !ramp_stop)
    else $error("ramp stop in hold");
  a_hold_speed: assert property (speed_up |-> freq_hold || $past(freq_hold))
    else $error("speed up outside hold");
  a_trip_pulse: assert property (trip_reset |=> !trip_reset) else $error("trip reset repeated");
  a_tx_stands: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte moved");
  a_rsp_addr: assert property ($rose(tx_valid) |-> tx_data == node_addr) else $error("response lacks address");
  a_rsp_func: assert property ($rose(tx_valid) && tx_ready |=> tx_data == FN_RW_MULTI)
    else $error("bad function");
  c_trip: cover property (trip_reset);
  c_rsp: cover property ($rose(tx_valid));
  c_speed: cover property (speed_up);
  c_rev: cover property (reverse);
endmodule : decoder_props
bind drive_fieldbus_control_word_decoder decoder_props props (.clk, .rst, .node_addr, .tx_ready, .tx_data,
  .tx_valid, .relay1_fn_cw, .relay2_fn_cw, .multi_setup_en, .relay1, .relay2, .setup_sel, .quick_stop,
  .ramp_stop, .freq_hold, .speed_up, .trip_reset, .reverse);
`default_nettype wire

// [verification/fieldbus_master.sv]
// Purpose: bus master sending telegrams and collecting answers
// Assumes: byte-level stream on the decoder clock
// Notes: tx_ready stalls at random to stretch answers
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master
(
  input wire logic clk,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_frame_end,
  output logic tx_ready
);
  logic [7:0] rsp[$];
  initial
  begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
    tx_ready = 1'b1;
  end
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready)
      rsp.push_back(tx_data);
    #1;
    tx_ready = ($urandom_range(3) != 0);
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc16
  // bad flips one check bit so the residue cannot match
  task automatic send(input logic [7:0] f[$], input bit bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    rsp.delete();
    foreach (f[i])
    begin
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_data = f[i];
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    @(posedge clk);
    #1;
    rx_frame_end = 1'b1;
    @(posedge clk);
    #1;
    rx_frame_end = 1'b0;
  endtask : send
endmodule : fieldbus_master
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: self-checking bench of the command word decoder
// Assumes: master model drives the byte stream
// Notes: expectations come from a bench-side register model
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst;
  logic [7:0] rx_data, tx_data, node;
  logic rx_valid, rx_frame_end, tx_ready, tx_valid, r1f, r2f, mse;
  logic [5:0] di;
  logic [1:0] cg, rg, preset_sel;
  logic dc_brake, motor_coast, quick_stop, freq_hold, ramp_stop, speed_up, speed_down, trip_reset;
  logic jog, ramp_set2, relay1, relay2, setup_sel, reverse;
  logic [15:0] cmd_model;
  logic [15:0] mem [8];
  int err_count, samples_checked, trips, exp_trips;
  always #5 clk = ~clk;
  drive_fieldbus_control_word_decoder dut (.clk(clk), .rst(rst), .node_addr(node), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_frame_end(rx_frame_end), .tx_ready(tx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .di_coast_n(di[0]), .di_brake_n(di[1]), .di_coast_rst_n(di[2]), .di_speed_up(di[3]), .di_speed_down(di[4]),
    .di_reverse(di[5]), .coast_gate(cg), .reverse_gate(rg), .relay1_fn_cw(r1f), .relay2_fn_cw(r2f),
    .multi_setup_en(mse), .preset_sel(preset_sel), .dc_brake(dc_brake), .motor_coast(motor_coast),
    .quick_stop(quick_stop), .freq_hold(freq_hold), .ramp_stop(ramp_stop), .speed_up(speed_up),
    .speed_down(speed_down), .trip_reset(trip_reset), .jog(jog), .ramp_set2(ramp_set2), .relay1(relay1),
    .relay2(relay2), .setup_sel(setup_sel), .reverse(reverse));
  fieldbus_master m (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end), .tx_ready(tx_ready));
  always @(posedge clk) if (trip_reset === 1'b1) trips++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  function automatic logic g(input logic [1:0] s, input logic b, input logic d);
    return s == 2'h0 ? d : s == 2'h1 ? b : s == 2'h2 ? (b | d) : (b & d);
  endfunction : g
  function automatic logic [14:0] exp_out();
    logic h;
    logic [15:0] c;
    c = cmd_model;
    h = ~c[5];
    return {c[1:0], h & di[3], h & di[4], g(rg == 2'h1 ? 2'h0 : rg, c[15], di[5]), c[13] & mse, c[12] & r2f,
      c[11] & r1f, c[9], c[8], ~c[6] & ~h, h, ~c[4] & ~h, g(cg, ~c[3], ~di[0] | ~di[2]), ~c[2] | ~di[1]};
  endfunction : exp_out
  function automatic logic [15:0] rd(input int n);
    logic [14:0] o;
    o = exp_out();
    if (n == 1) return {5'h00, o[10:0]};
    return (n > 1 && n < 8) ? mem[n] : 16'h0000;
  endfunction : rd
  task automatic chk_out();
    logic [14:0] o;
    o = exp_out();
    check(16'(preset_sel), 16'(o[14:13]));
    check(16'({speed_up, speed_down, freq_hold}), 16'({o[12:11], o[3]}));
    check(16'({reverse, setup_sel, relay2, relay1}), 16'(o[10:7]));
    check(16'({ramp_set2, jog, ramp_stop, quick_stop}), 16'({o[6:4], o[2]}));
    check(16'({motor_coast, dc_brake}), 16'(o[1:0]));
  endtask : chk_out
  task automatic txn(input int rs, input int rq, input int ws, input logic [15:0] w[$], input bit bad);
    logic [7:0] f[$];
    logic [7:0] e[$];
    logic [15:0] v;
    int n;
    f = {node, 8'h17, 8'(rs >> 8), 8'(rs), 8'(rq >> 8), 8'(rq), 8'(ws >> 8), 8'(ws), 8'h00, 8'(w.size()),
      8'(2 * w.size())};
    foreach (w[i]) f = {f, w[i][15:8], w[i][7:0]};
    m.send(f, bad);
    if (bad)
    begin
      repeat (40) @(posedge clk);
      #1;
      check(16'(m.rsp.size()), 16'h0000);
      return;
    end
    foreach (w[i])
    begin
      n = ws + i;
      if (n == 0 && w[i][10])
      begin
        if (w[i][7] && !cmd_model[7]) exp_trips++;
        cmd_model = w[i];
      end
      else if (n > 1 && n < 8) mem[n] = w[i];
    end
    e = {node, 8'h17, 8'(2 * rq)};
    for (int k = 0; k < rq; k++)
    begin
      v = rd(rs + k);
      e = {e, v[15:8], v[7:0]};
    end
    v = m.crc16(e);
    e = {e, v[7:0], v[15:8]};
    repeat (300)
    begin
      if (m.rsp.size() >= e.size()) break;
      @(posedge clk);
    end
    // idle edges expose a byte beyond the check or a valid that never drops
    repeat (4) @(posedge clk);
    #1;
    check({15'h0000, tx_valid}, 16'h0000);
    check(16'(m.rsp.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, m.rsp[i]}, {8'h00, e[i]});
  endtask : txn
  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial
  begin
    // about seventy telegrams of well under a hundred cycles each
    #300000;
    err_count++;
    summarize();
  end
  initial
  begin
    logic [15:0] w[$];
    logic [15:0] seq[6];
    void'($urandom(74));
    {rst, node, di, cg, rg, r1f, r2f, mse} = {1'b1, 8'h5A, 6'h07, 2'h1, 2'h2, 3'h7};
    cmd_model = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    txn(2, 6, 2, {16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666}, 1'b0);
    txn(3, 2, 3, {16'hC350, 16'h0000}, 1'b0);
    txn(6, 4, 6, {16'h1234, 16'h5678}, 1'b0);
    txn(2, 1, 0, {16'h04FF}, 1'b1);
    chk_out();
    seq = '{16'h0480, 16'h0480, 16'h0080, 16'h0480, 16'h0400, 16'h0480};
    foreach (seq[i]) txn(2, 1, 0, {seq[i]}, 1'b0);
    check(16'(trips), 16'(exp_trips));
    repeat (30)
    begin
      @(posedge clk);
      #1;
      {di, cg, rg, r1f, r2f, mse} = 13'($urandom);
      w = {16'($urandom)};
      txn(2 + $urandom_range(7), 1 + $urandom_range(2), 0, w, 1'b0);
      chk_out();
      w = {16'($urandom), 16'($urandom)};
      txn(1, 1 + $urandom_range(3), 2 + $urandom_range(5), w, 1'b0);
    end
    check(16'(trips), 16'(exp_trips));
    summarize();
  end
endmodule : tb_top
`default_nettype wire
